// ---- rtl/spsr_cfg.svh ----
// Constants of the serial port status reporter: status codes, widths, timing.
// Assumes one 100 MHz core clock; times are given in microseconds.
`ifndef SPSR_CFG_SVH
`define SPSR_CFG_SVH

`define SPSR_CLK_MHZ          100
`define SPSR_TIME_W           16
`define SPSR_CNT_W            32
// Transmit configuration errors
`define SPSR_ST_TX_PROTO      16'h80b0
`define SPSR_ST_TX_BAUD       16'h80b1
`define SPSR_ST_TX_PARITY     16'h80b2
`define SPSR_ST_TX_DBITS      16'h80b3
`define SPSR_ST_TX_SBITS      16'h80b4
`define SPSR_ST_TX_FLOW       16'h80b5
// Receive configuration errors, plus the response timeout 80c8
`define SPSR_ST_RX_NOFF       16'h80c4
`define SPSR_ST_RX_LSIZE      16'h80c5
`define SPSR_ST_RX_MCNT       16'h80c6
`define SPSR_ST_RX_NLM        16'h80c7
`define SPSR_ST_RX_RESP_TO    16'h80c8
`define SPSR_ST_RX_GAP_CFG    16'h80c9
`define SPSR_ST_RX_IDLE_CFG   16'h80ca
`define SPSR_ST_RX_END_WILD   16'h80cb
`define SPSR_ST_RX_START_WILD 16'h80cc
// Transmit runtime
`define SPSR_ST_TX_ACTIVE     16'h80d0
`define SPSR_ST_TX_FLOW_TO    16'h80d1
`define SPSR_ST_TX_NO_DSR     16'h80d2
`define SPSR_ST_TX_BUF        16'h80d3
`define SPSR_ST_TX_IDLE       16'h7000
`define SPSR_ST_TX_FIRST      16'h7001
`define SPSR_ST_TX_POLL       16'h7002
// Receive runtime
`define SPSR_ST_RX_BUF_FULL   16'h80e0
`define SPSR_ST_RX_PARITY     16'h80e1
`define SPSR_ST_RX_FRAMING    16'h80e2
`define SPSR_ST_RX_OVERRUN    16'h80e3
`define SPSR_ST_RX_LEN_BIG    16'h80e4
`define SPSR_ST_RX_MAX_MESSAGE_LENGTH     16'h0094
`define SPSR_ST_RX_MSG_TO     16'h0095
`define SPSR_ST_RX_GAP_TO     16'h0096
`define SPSR_ST_RX_FIRST_TO   16'h0097
`define SPSR_ST_RX_NLM_DONE   16'h0098
`define SPSR_ST_RX_END_DONE   16'h0099
// Signal handling
`define SPSR_ST_SIG_NONE      16'h80f0
`define SPSR_ST_SIG_HWFLOW    16'h80f1
`define SPSR_ST_SIG_DSR_DTE   16'h80f2
// Hardware flow type code and configuration limits
`define SPSR_FLOW_HW          2'h1
`define SPSR_MAX_LEN_BYTES    2'h2

`endif

// ---- rtl/spsr_pkg.sv ----
// Types of the serial port status reporter.
// Assumes spsr_cfg.svh gives the widths.
`include "spsr_cfg.svh"

package spsr_pkg;

  // Transmit configuration presented with a request
  typedef struct packed {
    logic       proto_ok;
    logic       baud_ok;
    logic       parity_ok;
    logic       dbits_ok;
    logic       sbits_ok;
    logic       flow_ok;
    logic [1:0] flow_type;
  } spsr_tx_cfg_t;

  // Receive configuration presented with a request
  typedef struct packed {
    logic [7:0]                n_offset;
    logic [1:0]                len_size;
    logic [7:0]                m_trailer;
    logic                      nlm_en;
    logic                      end_en;
    logic                      start_en;
    logic                      end_all_wild;
    logic                      start_all_wild;
    logic                      gap_cfg_bad;
    logic                      idle_cfg_bad;
    logic [15:0]               max_message_length;
    logic [`SPSR_TIME_W-1:0]   first_char_timeout;
    logic [`SPSR_TIME_W-1:0]   whole_message_timeout;
    logic [`SPSR_TIME_W-1:0]   inter_char_gap_time;
  } spsr_rx_cfg_t;

  // One received character with its line condition
  typedef struct packed {
    logic       valid;
    logic       parity_err;
    logic       framing_err;
    logic       overrun_err;
    logic       end_seq_hit;
    logic [7:0] data;
  } spsr_rx_char_t;

  // Completion group shared by every operation
  typedef struct packed {
    logic        done;
    logic        error;
    logic [15:0] status;
  } spsr_result_t;

  typedef enum logic [1:0] {
    SPSR_TX_IDLE = 2'b00,
    SPSR_TX_WAIT = 2'b01,
    SPSR_TX_SEND = 2'b10
  } spsr_tx_state_t;

  typedef enum logic [1:0] {
    SPSR_RX_IDLE  = 2'b00,
    SPSR_RX_FIRST = 2'b01,
    SPSR_RX_BODY  = 2'b10
  } spsr_rx_state_t;

endpackage

// ---- rtl/spsr_timer.sv ----
// Down-counting timeout timer converting microseconds into core clocks.
// Assumes a synchronous active-low reset and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "spsr_cfg.svh"

module spsr_timer #(
  parameter int TIME_W = `SPSR_TIME_W,
  parameter int CNT_W  = `SPSR_CNT_W
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // Control
  input  wire logic              start,
  input  wire logic              run,
  input  wire logic [TIME_W-1:0] time_us,
  // Result
  output logic                   expired
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             exp_r;
  logic             exp_nxt;

  // Load on start; a zero time never expires, so it disables the check
  always_comb begin
    cnt_nxt = cnt_r;
    exp_nxt = 1'b0;
    if (start) begin
      cnt_nxt = CNT_W'(time_us) * CNT_W'(`SPSR_CLK_MHZ);
    end else if (run && cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
      exp_nxt = (cnt_r == CNT_W'(1));
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired = exp_r;

endmodule
`default_nettype wire

// ---- rtl/spsr_top.sv ----
// Serial port status reporter: checks configuration, tracks transmit and receive
// progress and turns every outcome into a status word with done/error pulses.
// Assumes all inputs are synchronous to core_clk; one scan is one clock.
`timescale 1ns/1ps
`default_nettype none
`include "spsr_cfg.svh"

module spsr_top
  import spsr_pkg::*;
#(
  parameter int TX_BUF_BYTES = 1024,
  parameter int RX_BUF_BYTES = 1024
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  // Port identity and line state
  input  wire logic          port_two_wire,
  input  wire logic          port_is_dte,
  input  wire logic          dsr_in,
  input  wire logic          cts_in,
  input  wire logic          xoff_in,
  // Transmit request
  input  wire logic          tx_req,
  input  wire spsr_tx_cfg_t  tx_cfg,
  input  wire logic [15:0]   tx_len,
  input  wire logic [15:0]   tx_wait_us,
  input  wire logic          tx_byte_sent,
  // Transmit result
  output spsr_result_t       tx_res,
  output logic               tx_active,
  // Receive request
  input  wire logic          rx_req,
  input  wire spsr_rx_cfg_t  rx_cfg,
  input  wire spsr_rx_char_t rx_char,
  // Receive result
  output spsr_result_t       rx_res,
  output logic [15:0]        rx_count,
  // Signal set request
  input  wire logic          sig_req,
  input  wire logic [2:0]    sig_select,
  // Signal result
  output spsr_result_t       sig_res
);

  // Whole module state
  typedef struct packed {
    spsr_tx_state_t tx_st;
    logic [15:0]    tx_left;
    logic           tx_first;
    spsr_result_t   tx_res;
    spsr_rx_state_t rx_st;
    logic [15:0]    rx_cnt;
    logic [15:0]    rx_target;
    logic [15:0]    rx_len_acc;
    logic [1:0]     rx_len_idx;
    spsr_rx_cfg_t   rx_cfg;
    spsr_result_t   rx_res;
    spsr_result_t   sig_res;
  } spsr_state_t;

  spsr_state_t st_r;
  spsr_state_t st_nxt;

  logic tx_start;
  logic tx_wait_run;
  logic tx_wait_exp;
  logic rx_start;
  logic first_exp;
  logic msg_exp;
  logic gap_exp;
  logic gap_restart;
  logic rx_char_ok;

  spsr_timer u_tx_wait (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (tx_start),
    .run      (tx_wait_run),
    .time_us  (tx_wait_us),
    .expired  (tx_wait_exp)
  );

  spsr_timer u_first (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (rx_start),
    .run      (st_r.rx_st == SPSR_RX_FIRST),
    .time_us  (rx_cfg.first_char_timeout),
    .expired  (first_exp)
  );

  spsr_timer u_msg (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (rx_start),
    .run      (st_r.rx_st != SPSR_RX_IDLE),
    .time_us  (rx_cfg.whole_message_timeout),
    .expired  (msg_exp)
  );

  spsr_timer u_gap (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (gap_restart),
    .run      (st_r.rx_st == SPSR_RX_BODY),
    .time_us  (st_r.rx_cfg.inter_char_gap_time),
    .expired  (gap_exp)
  );

  // Timer steering from the current state and requests
  always_comb begin
    tx_start    = tx_req && st_r.tx_st == SPSR_TX_IDLE;
    tx_wait_run = (st_r.tx_st == SPSR_TX_WAIT) || (st_r.tx_st == SPSR_TX_SEND && xoff_in);
    rx_start    = rx_req && st_r.rx_st == SPSR_RX_IDLE;
    rx_char_ok  = rx_char.valid && st_r.rx_st != SPSR_RX_IDLE;
    gap_restart = rx_char_ok;
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_res.done   = 1'b0;
    st_nxt.tx_res.error  = 1'b0;
    st_nxt.rx_res.done   = 1'b0;
    st_nxt.rx_res.error  = 1'b0;
    st_nxt.sig_res.done  = 1'b0;
    st_nxt.sig_res.error = 1'b0;

    // Transmitter
    unique case (st_r.tx_st)
      SPSR_TX_IDLE: begin
        if (tx_req) begin
          st_nxt.tx_res.error = 1'b1;
          if (!tx_cfg.proto_ok) begin
            st_nxt.tx_res.status = `SPSR_ST_TX_PROTO;
          end else if (!tx_cfg.baud_ok) begin
            st_nxt.tx_res.status = `SPSR_ST_TX_BAUD;
          end else if (!tx_cfg.parity_ok) begin
            st_nxt.tx_res.status = `SPSR_ST_TX_PARITY;
          end else if (!tx_cfg.dbits_ok) begin
            st_nxt.tx_res.status = `SPSR_ST_TX_DBITS;
          end else if (!tx_cfg.sbits_ok) begin
            st_nxt.tx_res.status = `SPSR_ST_TX_SBITS;
          end else if (!tx_cfg.flow_ok) begin
            st_nxt.tx_res.status = `SPSR_ST_TX_FLOW;
          end else if (32'(tx_len) > TX_BUF_BYTES) begin
            st_nxt.tx_res.status = `SPSR_ST_TX_BUF;
          // DTE needs DSR from the partner
          end else if (port_is_dte && !port_two_wire && !dsr_in) begin
            st_nxt.tx_res.status = `SPSR_ST_TX_NO_DSR;
          end else begin
            st_nxt.tx_res.error  = 1'b0;
            st_nxt.tx_res.status = `SPSR_ST_TX_FIRST;
            st_nxt.tx_left       = tx_len;
            st_nxt.tx_first      = 1'b1;
            st_nxt.tx_st = (tx_cfg.flow_type == `SPSR_FLOW_HW && !port_two_wire)
                           ? SPSR_TX_WAIT : SPSR_TX_SEND;
          end
        end
      end
      SPSR_TX_WAIT: begin
        // CTS must arrive within the wait time
        if (cts_in) begin
          st_nxt.tx_st = SPSR_TX_SEND;
        end else if (tx_wait_exp) begin
          st_nxt.tx_st        = SPSR_TX_IDLE;
          st_nxt.tx_res.error = 1'b1;
          st_nxt.tx_res.status = `SPSR_ST_TX_FLOW_TO;
        end
      end
      SPSR_TX_SEND: begin
        if (tx_byte_sent && st_r.tx_left != 16'h0000) begin
          st_nxt.tx_left = st_r.tx_left - 16'h0001;
        end
        if (tx_wait_exp) begin
          st_nxt.tx_st         = SPSR_TX_IDLE;
          st_nxt.tx_res.error  = 1'b1;
          st_nxt.tx_res.status = `SPSR_ST_TX_FLOW_TO;
        end else if (st_r.tx_left == 16'h0000 ||
                     (tx_byte_sent && st_r.tx_left == 16'h0001)) begin
          st_nxt.tx_st         = SPSR_TX_IDLE;
          st_nxt.tx_res.done   = 1'b1;
          st_nxt.tx_res.status = `SPSR_ST_TX_IDLE;
        end
      end
      default: st_nxt.tx_st = SPSR_TX_IDLE;
    endcase

    if (st_r.tx_st != SPSR_TX_IDLE) begin
      // 7001 stands for the first cycle only; later polls report 7002
      if (st_nxt.tx_st != SPSR_TX_IDLE) begin
        st_nxt.tx_res.status = `SPSR_ST_TX_POLL;
      end
      if (tx_req && st_nxt.tx_st != SPSR_TX_IDLE) begin
        st_nxt.tx_res.error  = 1'b1;
        st_nxt.tx_res.status = `SPSR_ST_TX_ACTIVE;
      end
    end

    // Receiver
    unique case (st_r.rx_st)
      SPSR_RX_IDLE: begin
        if (rx_req) begin
          st_nxt.rx_res.error = 1'b1;
          if (rx_cfg.nlm_en && 32'(rx_cfg.n_offset) > RX_BUF_BYTES) begin
            st_nxt.rx_res.status = `SPSR_ST_RX_NOFF;
          end else if (rx_cfg.nlm_en && (rx_cfg.len_size == 2'h0 ||
                       rx_cfg.len_size > `SPSR_MAX_LEN_BYTES)) begin
            st_nxt.rx_res.status = `SPSR_ST_RX_LSIZE;
          end else if (rx_cfg.nlm_en && 32'(rx_cfg.m_trailer) > RX_BUF_BYTES) begin
            st_nxt.rx_res.status = `SPSR_ST_RX_MCNT;
          end else if (rx_cfg.nlm_en && 32'(rx_cfg.n_offset) + 32'(rx_cfg.len_size)
                       + 32'(rx_cfg.m_trailer) > RX_BUF_BYTES) begin
            st_nxt.rx_res.status = `SPSR_ST_RX_NLM;
          end else if (rx_cfg.gap_cfg_bad) begin
            st_nxt.rx_res.status = `SPSR_ST_RX_GAP_CFG;
          end else if (rx_cfg.idle_cfg_bad) begin
            st_nxt.rx_res.status = `SPSR_ST_RX_IDLE_CFG;
          end else if (rx_cfg.end_en && rx_cfg.end_all_wild) begin
            st_nxt.rx_res.status = `SPSR_ST_RX_END_WILD;
          end else if (rx_cfg.start_en && rx_cfg.start_all_wild) begin
            st_nxt.rx_res.status = `SPSR_ST_RX_START_WILD;
          end else begin
            st_nxt.rx_res.error  = 1'b0;
            st_nxt.rx_res.status = 16'h0000;
            st_nxt.rx_cfg        = rx_cfg;
            st_nxt.rx_cnt        = 16'h0000;
            st_nxt.rx_target     = 16'h0000;
            st_nxt.rx_len_acc    = 16'h0000;
            st_nxt.rx_len_idx    = 2'h0;
            st_nxt.rx_st         = SPSR_RX_FIRST;
          end
        end
      end
      SPSR_RX_FIRST,
      SPSR_RX_BODY: begin
        if (rx_char_ok) begin
          st_nxt.rx_st  = SPSR_RX_BODY;
          st_nxt.rx_cnt = st_r.rx_cnt + 16'h0001;
          // Gather the length field after the leading offset
          if (st_r.rx_cfg.nlm_en && st_r.rx_cnt >= 16'(st_r.rx_cfg.n_offset)
              && st_r.rx_len_idx < st_r.rx_cfg.len_size) begin
            st_nxt.rx_len_acc = {st_r.rx_len_acc[7:0], rx_char.data};
            st_nxt.rx_len_idx = st_r.rx_len_idx + 2'h1;
            if (st_r.rx_len_idx + 2'h1 == st_r.rx_cfg.len_size) begin
              st_nxt.rx_target = 16'(st_r.rx_cfg.n_offset) + 16'(st_r.rx_cfg.len_size)
                                 + {st_r.rx_len_acc[7:0], rx_char.data}
                                 + 16'(st_r.rx_cfg.m_trailer);
            end
          end
        end
        // Ending causes: line errors first, then lengths and the end sequence, then timeouts
        st_nxt.rx_res.error = 1'b1;
        st_nxt.rx_st        = SPSR_RX_IDLE;
        if (rx_char_ok && rx_char.parity_err) begin
          st_nxt.rx_res.status = `SPSR_ST_RX_PARITY;
        end else if (rx_char_ok && rx_char.framing_err) begin
          st_nxt.rx_res.status = `SPSR_ST_RX_FRAMING;
        end else if (rx_char_ok && rx_char.overrun_err) begin
          st_nxt.rx_res.status = `SPSR_ST_RX_OVERRUN;
        end else if (st_nxt.rx_target != 16'h0000 && 32'(st_nxt.rx_target) > RX_BUF_BYTES) begin
          st_nxt.rx_res.status = `SPSR_ST_RX_LEN_BIG;
        end else if (st_nxt.rx_target != 16'h0000 && st_nxt.rx_cnt == st_nxt.rx_target) begin
          st_nxt.rx_res       = '{done: 1'b1, error: 1'b0, status: `SPSR_ST_RX_NLM_DONE};
        end else if (rx_char_ok && st_r.rx_cfg.end_en && rx_char.end_seq_hit) begin
          st_nxt.rx_res       = '{done: 1'b1, error: 1'b0, status: `SPSR_ST_RX_END_DONE};
        end else if (st_r.rx_cfg.max_message_length != 16'h0000 &&
                     st_nxt.rx_cnt == st_r.rx_cfg.max_message_length) begin
          st_nxt.rx_res       = '{done: 1'b1, error: 1'b0, status: `SPSR_ST_RX_MAX_MESSAGE_LENGTH};
        end else if (32'(st_nxt.rx_cnt) >= RX_BUF_BYTES) begin
          st_nxt.rx_res.status = `SPSR_ST_RX_BUF_FULL;
        end else if (st_r.rx_st == SPSR_RX_FIRST && first_exp) begin
          st_nxt.rx_res       = '{done: 1'b1, error: 1'b0, status: `SPSR_ST_RX_FIRST_TO};
        // nothing received in the receive period
        end else if (st_r.rx_st == SPSR_RX_FIRST && msg_exp) begin
          st_nxt.rx_res.status = `SPSR_ST_RX_RESP_TO;
        end else if (msg_exp && !rx_char_ok) begin
          st_nxt.rx_res       = '{done: 1'b1, error: 1'b0, status: `SPSR_ST_RX_MSG_TO};
        end else if (st_r.rx_st == SPSR_RX_BODY && gap_exp && !rx_char_ok) begin
          st_nxt.rx_res       = '{done: 1'b1, error: 1'b0, status: `SPSR_ST_RX_GAP_TO};
        end else begin
          st_nxt.rx_res.error = 1'b0;
          st_nxt.rx_st        = rx_char_ok ? SPSR_RX_BODY : st_r.rx_st;
        end
      end
      default: st_nxt.rx_st = SPSR_RX_IDLE;
    endcase

    // Signal set requests: bit0 RTS, bit1 DTR, bit2 DSR
    if (sig_req) begin
      st_nxt.sig_res.error = 1'b1;
      // no handshake lines on two-wire port
      if (port_two_wire) begin
        st_nxt.sig_res.status = `SPSR_ST_SIG_NONE;
      end else if (tx_cfg.flow_type == `SPSR_FLOW_HW) begin
        st_nxt.sig_res.status = `SPSR_ST_SIG_HWFLOW;
      end else if (port_is_dte && sig_select[2]) begin
        st_nxt.sig_res.status = `SPSR_ST_SIG_DSR_DTE;
      end else begin
        st_nxt.sig_res.error  = 1'b0;
        st_nxt.sig_res.done   = 1'b1;
        st_nxt.sig_res.status = 16'h0000;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_r               <= '0;
      st_r.tx_st         <= SPSR_TX_IDLE;
      st_r.rx_st         <= SPSR_RX_IDLE;
      st_r.tx_res.status <= `SPSR_ST_TX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign tx_res    = st_r.tx_res;
  assign tx_active = st_r.tx_st != SPSR_TX_IDLE;
  assign rx_res    = st_r.rx_res;
  assign rx_count  = st_r.rx_cnt;
  assign sig_res   = st_r.sig_res;

endmodule
`default_nettype wire

// ---- dv/spsr_top_checker.sv ----
// Checker of the status reporter outputs against its request inputs.
// Assumes it is bound into spsr_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module spsr_top_checker
  import spsr_pkg::*;
(
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         rst_b,
  // Requests and port state
  input wire logic         port_two_wire,
  input wire logic         port_is_dte,
  input wire logic         tx_req,
  input wire spsr_tx_cfg_t tx_cfg,
  input wire logic         rx_req,
  input wire logic         sig_req,
  input wire logic [2:0]   sig_select,
  // Results
  input wire spsr_result_t tx_res,
  input wire logic         tx_active,
  input wire spsr_result_t rx_res,
  input wire spsr_result_t sig_res
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Transmit progress codes follow the busy level
  chk_tx_first: assert property ($rose(tx_active) |-> tx_res.status == 16'h7001)
    else $error("first transmit status wrong");
  chk_tx_poll: assert property (tx_active && $past(tx_active) && !tx_res.error
    |-> tx_res.status == 16'h7002)
    else $error("transmit poll status wrong");
  chk_tx_idle: assert property (tx_res.done |-> tx_res.status == 16'h7000 && !tx_active)
    else $error("transmit end status wrong");
  // A refused request must not end the running transfer
  chk_busy_refuse: assert property (tx_req && tx_active
    |=> tx_res.error && tx_res.status == 16'h80d0 && tx_active)
    else $error("busy refusal wrong");
  chk_done_pulse: assert property (tx_res.done |=> !tx_res.done)
    else $error("done wider than one cycle");
  chk_rx_hold: assert property (!rx_res.done && !rx_res.error && !$past(rx_req)
    |-> $stable(rx_res.status))
    else $error("receive status moved without cause");
  // Signal set refusals
  chk_sig_two_wire: assert property (sig_req && port_two_wire
    |=> sig_res.error && sig_res.status == 16'h80f0)
    else $error("two wire refusal wrong");
  chk_sig_hw_flow: assert property (sig_req && !port_two_wire && tx_cfg.flow_type == 2'h1
    |=> sig_res.error && sig_res.status == 16'h80f1)
    else $error("hardware flow refusal wrong");
  chk_sig_dsr_dte: assert property (sig_req && !port_two_wire && tx_cfg.flow_type != 2'h1
    && port_is_dte && sig_select[2] |=> sig_res.error && sig_res.status == 16'h80f2)
    else $error("terminal side refusal wrong");
endmodule

bind spsr_top spsr_top_checker u_spsr_top_checker (.core_clk, .rst_b, .port_two_wire, .port_is_dte,
  .tx_req, .tx_cfg, .rx_req, .sig_req, .sig_select, .tx_res, .tx_active, .rx_res, .sig_res);
`default_nettype wire

// ---- dv/spsr_partner.sv ----
// Remote serial partner: flow lines, byte pacing and received characters.
// Assumes its inputs are synchronous to core_clk; the bench commands it.
`timescale 1ns/1ps
`default_nettype none
module spsr_partner
  import spsr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Commands from the bench
  input  wire logic       cts_ok,
  input  wire logic       dsr_ok,
  input  wire logic       xoff_on,
  input  wire logic [7:0] byte_gap,
  // Line toward the block
  input  wire logic       tx_active,
  output logic            cts_in,
  output logic            dsr_in,
  output logic            xoff_in,
  output logic            tx_byte_sent,
  output spsr_rx_char_t   rx_char
);
  logic [7:0] gap_r;
  // clear to send
  // A receiver that is not ready keeps CTS low, so the wait timer runs out
  assign cts_in = cts_ok;
  assign dsr_in = dsr_ok;
  // Software hold-off follows the bench, so the suspend timer can be exercised
  assign xoff_in = xoff_on;
  // One byte leaves every byte_gap+1 cycles; none while held off or not cleared
  always_ff @(posedge core_clk) begin
    tx_byte_sent <= 1'b0;
    if (!rst_b || !tx_active || !cts_in || xoff_in) begin
      gap_r <= 8'h00;
    end else if (gap_r == byte_gap) begin
      gap_r <= 8'h00;
      tx_byte_sent <= 1'b1;
    end else begin
      gap_r <= gap_r + 8'h01;
    end
  end
  // Flags are parity, framing, overrun, end hit; data is scrambled after release
  task automatic send_char(input logic [3:0] flags, input logic [7:0] data);
    @(posedge core_clk);
    rx_char <= {1'b1, flags, data};
    @(posedge core_clk);
    rx_char <= {1'b0, 4'h0, ~data};
  endtask
  initial rx_char = '0;
endmodule
`default_nettype wire

// ---- dv/spsr_top_bench.sv ----
// Self-checking bench of the serial port status reporter.
// Assumes a 100 MHz core clock and the partner model on the line side.
`timescale 1ns/1ps
`default_nettype none
module spsr_top_bench
  import spsr_pkg::*;
;
  logic          core_clk = 1'b0, rst_b = 1'b0, port_two_wire = 1'b0, port_is_dte = 1'b0;
  logic          tx_req = 1'b0, rx_req = 1'b0, sig_req = 1'b0, cts_ok = 1'b1, dsr_ok = 1'b1;
  logic          xoff_on = 1'b0;
  logic          tx_active, cts_in, dsr_in, xoff_in, tx_byte_sent;
  logic [7:0]    byte_gap = 8'h30;
  logic [15:0]   tx_len = 16'h0003, tx_wait_us = 16'h0000, rx_count;
  logic [2:0]    sig_select = 3'h4;
  spsr_tx_cfg_t  tx_cfg = 8'hfc;
  spsr_rx_cfg_t  rx_cfg;
  spsr_rx_char_t rx_char;
  spsr_result_t  tx_res, rx_res, sig_res;
  int            n_errors = 0, n_tests = 0;

  spsr_top u_spsr_top (.core_clk, .rst_b, .port_two_wire, .port_is_dte, .dsr_in, .cts_in, .xoff_in,
    .tx_req, .tx_cfg, .tx_len, .tx_wait_us, .tx_byte_sent, .tx_res, .tx_active, .rx_req, .rx_cfg,
    .rx_char, .rx_res, .rx_count, .sig_req, .sig_select, .sig_res);
  spsr_partner u_spsr_partner (.core_clk, .rst_b, .cts_ok, .dsr_ok, .xoff_on, .byte_gap,
    .tx_active, .cts_in, .dsr_in, .xoff_in, .tx_byte_sent, .rx_char);

  // Free-running core clock
  always #5 core_clk = ~core_clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One-cycle request: 0 transmit, 1 receive, 2 signal set
  task automatic pulse(input int k);
    @(posedge core_clk);
    tx_req <= (k == 0);
    rx_req <= (k == 1);
    sig_req <= (k == 2);
    @(posedge core_clk);
    {tx_req, rx_req, sig_req} <= 3'h0;
  endtask

  // Bounded wait for the done or error pulse, then judge flags and code
  // The pulse stands one cycle from the taking edge, so look before the next edge
  task automatic wait_res(input int k, input logic [15:0] exp, input logic err);
    spsr_result_t r;
    #1;
    r = (k == 0) ? tx_res : (k == 1) ? rx_res : sig_res;
    for (int i = 0; i < 3000 && !(r.done || r.error); i++) begin
      @(posedge core_clk);
      #1;
      r = (k == 0) ? tx_res : (k == 1) ? rx_res : sig_res;
    end
    if (!(r.done || r.error)) begin
      n_errors++;
      $display("ERROR %0t: no result before the limit", $time);
      finish_test();
    end
    check({14'h0, r.done, r.error}, {14'h0, !err, err});
    check(r.status, exp);
  endtask

  // Each unsupported transmit setting in turn
  task automatic t_tx_cfg();
    for (int i = 0; i < 6; i++) begin
      tx_cfg <= 8'hfc ^ (8'h80 >> i);
      pulse(0);
      wait_res(0, 16'h80b0 + 16'(i), 1'b1);
    end
    tx_cfg <= 8'hfc;
  endtask

  // Slow transfer with a refused second request in mid-flight
  task automatic t_tx_run();
    pulse(0);
    #1;
    check({15'h0, tx_active}, 16'h0001);
    check(tx_res.status, 16'h7001);
    @(posedge core_clk);
    #1;
    check(tx_res.status, 16'h7002);
    pulse(0);
    wait_res(0, 16'h80d0, 1'b1);
    @(posedge core_clk);
    #1;
    check(tx_res.status, 16'h7002);
    wait_res(0, 16'h7000, 1'b0);
    check({15'h0, tx_active}, 16'h0000);
  endtask

  // Oversized data, missing DSR, held-off sending, then CTS never raised
  task automatic t_tx_abort();
    tx_len <= 16'h0401;
    pulse(0);
    wait_res(0, 16'h80d3, 1'b1);
    tx_len <= 16'h0003;
    port_is_dte <= 1'b1;
    dsr_ok <= 1'b0;
    pulse(0);
    wait_res(0, 16'h80d2, 1'b1);
    {port_is_dte, dsr_ok, xoff_on} <= 3'h3;
    tx_wait_us <= 16'h0001;
    pulse(0);
    wait_res(0, 16'h80d1, 1'b1);
    {xoff_on, cts_ok} <= 2'h0;
    tx_cfg <= 8'hfd;
    pulse(0);
    wait_res(0, 16'h80d1, 1'b1);
    cts_ok <= 1'b1;
  endtask

  // Signal set refusals, hardware flow still selected at entry
  task automatic t_sig();
    pulse(2);
    wait_res(2, 16'h80f1, 1'b1);
    tx_cfg <= 8'hfc;
    port_is_dte <= 1'b1;
    pulse(2);
    wait_res(2, 16'h80f2, 1'b1);
    port_two_wire <= 1'b1;
    pulse(2);
    wait_res(2, 16'h80f0, 1'b1);
    {port_two_wire, port_is_dte} <= 2'h0;
  endtask

  // Length reached, parity abort, bad settings, end sequence, late first character
  task automatic t_rx();
    pulse(1);
    repeat (3) u_spsr_partner.send_char(4'h0, 8'h5a);
    wait_res(1, 16'h0094, 1'b0);
    check(rx_count, 16'h0003);
    pulse(1);
    u_spsr_partner.send_char(4'h8, 8'h33);
    wait_res(1, 16'h80e1, 1'b1);
    rx_cfg.gap_cfg_bad <= 1'b1;
    pulse(1);
    wait_res(1, 16'h80c9, 1'b1);
    {rx_cfg.gap_cfg_bad, rx_cfg.end_en, rx_cfg.end_all_wild} <= 3'h3;
    pulse(1);
    wait_res(1, 16'h80cb, 1'b1);
    rx_cfg.end_all_wild <= 1'b0;
    pulse(1);
    u_spsr_partner.send_char(4'h1, 8'h0d);
    wait_res(1, 16'h0099, 1'b0);
    rx_cfg.first_char_timeout <= 16'h0001;
    pulse(1);
    wait_res(1, 16'h0097, 1'b0);
  endtask

  // Main sequence: reset, then every scenario, then the verdict
  initial begin
    rx_cfg = '0;
    rx_cfg.len_size = 2'h1;
    rx_cfg.max_message_length = 16'h0003;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    check(tx_res.status, 16'h7000);
    t_tx_cfg();
    t_tx_run();
    t_tx_abort();
    t_sig();
    t_rx();
    finish_test();
  end
endmodule
`default_nettype wire
